// ### flsrb_defs.svh
// Status bank constants.
// Assumes a 25 MHz core clock, mode 0 host.
// ------------
// Overview of operation
// R01: Byte one bit 0 busy during program, erase, status write.
// R02: While busy only status reads are obeyed.
// R03: Busy clears when that operation finishes.
// R04: Byte one bit 1 latch sets after write enable.
// R05: Latch clears on power-up, 04h, program, erase, status write.
// R06: Byte one bits 4..2 protect range; zero protects none.
// R07: Byte one bit 5: protect from top (0) or bottom (1).
// R08: Protect writes gated by guard mode and latch.
// R09: Byte one bit 6: 64 kB blocks (0) or 4 kB sectors (1).
// R10: Byte two bit 6 inverts the protect map.
// R11: Byte two bit 7 set while suspended.
// R12: Byte two bits 5..2 one-time security locks.
// R13: Lock zero reads one; host ignores it.
// R14: Byte two bit 1 quad: pins become data lines.
// R15: Byte two bit 0: pin guard, or lock-down and permanent lock.
// R16: After a volatile write, non-volatile writes need a reset.
// R17: Byte three bit 7: hold or reset pin role, without quad.
// R18: Byte three bit 4 enables fast quad pump.
// R19: Byte three bits 3..0 serial read dummy cycles; zero off.
// R20: Latency field is serial only; clears on quad exit.
// R21: Quad read latency is its own loaded setting.
// R22: Byte three bits 6..5 read drive strength.
// R23: Power-up or reset loads volatile copies from non-volatile.
// R24: Guard mode never blocks byte three writes.
// R25: Reads give volatile copies plus live busy, latch, suspend. Byte two lock bits 5..3 are read from the non-volatile copy instead.
// ------------
`ifndef FLSRB_DEFS_SVH
`define FLSRB_DEFS_SVH

// ------------
// Opcodes
// ------------
`define FLSRB_OP_WREN      8'h06
`define FLSRB_OP_VOL_WREN  8'h50
`define FLSRB_OP_WR_ONE    8'h01
`define FLSRB_OP_WR_TWO    8'h31
`define FLSRB_OP_WR_THREE  8'h11
`define FLSRB_OP_RST_ARM   8'h66
`define FLSRB_OP_RST_GO    8'h99

// ------------
// Bit positions
// ------------
`define FLSRB_B1_BUSY      0
`define FLSRB_B1_WPL       1
`define FLSRB_B1_BP_LO     2
`define FLSRB_B1_BP_HI     4
`define FLSRB_B1_BOTTOM    5
`define FLSRB_B1_GRAN      6
`define FLSRB_B1_GUARD_LO  7
`define FLSRB_B2_GUARD_HI  0
`define FLSRB_B2_QUAD      1
`define FLSRB_B2_LOCK_LO   2
`define FLSRB_B2_LOCK0     2
`define FLSRB_B2_LOCK_HI   5
`define FLSRB_B2_INVERT    6
`define FLSRB_B2_PAUSED    7
`define FLSRB_B3_WAIT_LO   0
`define FLSRB_B3_WAIT_HI   3
`define FLSRB_B3_PUMP      4
`define FLSRB_B3_DRV_LO    5
`define FLSRB_B3_DRV_HI    6
`define FLSRB_B3_ROLE      7

// ------------
// Masks and defaults
// ------------
`define FLSRB_M1_PROT      8'hfc
`define FLSRB_M2_PROT      8'h43
`define FLSRB_M2_LOCK      8'h3c
`define FLSRB_M2_GUARD_HI  8'h01
`define FLSRB_M3_WAIT      8'h0f
`define FLSRB_DEF_ONE      8'h00
`define FLSRB_DEF_TWO      8'h04
`define FLSRB_DEF_THREE    8'h00
`define FLSRB_DEF_WAIT     4'h0
`define FLSRB_BIT_LAST     3'h7
`define FLSRB_NB_ONE       2'h1
`define FLSRB_NB_TWO       2'h2
`define FLSRB_NB_MAX       2'h3
`define FLSRB_GUARD_SOFT   2'h0
`define FLSRB_GUARD_PIN    2'h1

// ------------
// Timing
// ------------
`define FLSRB_MCLK_MHZ     25
`define FLSRB_RST_TIME_NS  10000
`define FLSRB_RST_CYC      ((`FLSRB_RST_TIME_NS * `FLSRB_MCLK_MHZ + 999) / 1000)

`endif

// ### flsrb_pkg.sv
// Types shared by the flash status register bank.
// Assumes flsrb_defs.svh supplies the numeric constants.
package flsrb_pkg;
   typedef logic [7:0] flsrb_byte_t;
   typedef enum logic [1:0] {
      FLSRB_PH_OPC  = 2'b00,
      FLSRB_PH_DATA = 2'b01,
      FLSRB_PH_READ = 2'b10
   } flsrb_phase_t;
endpackage

// ### flsrb_status_bank.sv
// Flash status bytes with a serial command front end.
// Assumes engines pulse on the core clock; pins arrive raw.
`include "flsrb_defs.svh"

module flsrb_status_bank #(
   parameter logic [15:0] SRW_CYCLES       = 16'h0010,
   parameter logic [7:0]  OP_READ_ONE      = 8'h05,
   parameter logic [7:0]  OP_READ_TWO      = 8'h35,
   parameter logic [7:0]  OP_READ_THREE    = 8'h15,
   parameter logic [7:0]  OP_WRITE_DISABLE = 8'h04
) (
   // Clock, reset, enable
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_b,
   input  wire logic                 i_ce,
   // Serial pins
   input  wire logic                 i_sclk,
   input  wire logic                 i_cs_b,
   input  wire logic                 i_si,
   input  wire logic                 i_wp_b,
   output logic                      o_so,
   output logic                      o_so_oe_b,
   // Engine events
   input  wire logic                 i_array_op_start,
   input  wire logic                 i_array_op_done,
   input  wire logic                 i_suspend_set,
   input  wire logic                 i_resume,
   input  wire logic                 i_hw_reset_req,
   input  wire logic                 i_qpi_mode,
   input  wire logic                 i_qpi_wait_load,
   input  wire logic [3:0]           i_qpi_wait_value,
   // Status
   output logic                      o_cmd_ready,
   output logic                      o_busy,
   output logic                      o_write_permit_latch,
   output logic                      o_paused_flag,
   output flsrb_pkg::flsrb_byte_t    o_status_byte_one,
   output flsrb_pkg::flsrb_byte_t    o_status_byte_two,
   output flsrb_pkg::flsrb_byte_t    o_status_byte_three,
   // Protection and pin configuration
   output logic [2:0]                o_protect_range,
   output logic                      o_protect_from_bottom,
   output logic                      o_granule_size_select,
   output logic                      o_invert_protect_map,
   output logic [3:0]                o_otp_lock,
   output logic                      o_quad_io_enable,
   output logic                      o_wp_pin_guard,
   output logic                      o_hold_enable,
   output logic                      o_reset_pin_enable,
   output logic [1:0]                o_pad_strength,
   output logic                      o_fast_quad_pump_on,
   output logic [3:0]                o_read_wait_cycles
);
   import flsrb_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0]   sclk_sync_r;
   logic [1:0]   cs_sync_r;
   logic [1:0]   si_sync_r;
   logic [1:0]   wp_sync_r;
   logic         sclk_d_r;
   logic         cs_d_r;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sclk_sync_r <= 2'h0;
         cs_sync_r   <= 2'h3;
         si_sync_r   <= 2'h0;
         wp_sync_r   <= 2'h3;
         sclk_d_r    <= 1'b0;
         cs_d_r      <= 1'b1;
      end else if (i_ce) begin
         sclk_sync_r <= {sclk_sync_r[0], i_sclk};
         cs_sync_r   <= {cs_sync_r[0], i_cs_b};
         si_sync_r   <= {si_sync_r[0], i_si};
         wp_sync_r   <= {wp_sync_r[0], i_wp_b};
         sclk_d_r    <= sclk_sync_r[1];
         cs_d_r      <= cs_sync_r[1];
      end
   end

   wire sclk_s    = sclk_sync_r[1];
   wire cs_b_s    = cs_sync_r[1];
   wire si_s      = si_sync_r[1];
   wire wp_hi_s   = wp_sync_r[1];
   wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_b_s;
   wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_b_s;
   wire exec      = cs_b_s & ~cs_d_r;

   // ----------------------------------------------------------------
   // Serial shifter
   // ----------------------------------------------------------------
   flsrb_phase_t phase_r;
   flsrb_phase_t phase_nxt;
   logic [2:0]   bit_cnt_r;
   logic [1:0]   nbytes_r;
   logic [1:0]   nbytes_nxt;
   logic [7:0]   shift_r;
   logic [7:0]   op_r;
   logic [7:0]   data1_r;
   logic [7:0]   data2_r;
   logic [7:0]   tx_r;
   logic [7:0]   rd_byte;

   wire [7:0] byte_in   = {shift_r[6:0], si_s};
   wire       byte_done = sclk_rise & (bit_cnt_r == `FLSRB_BIT_LAST);
   wire       rd_in     = (byte_in == OP_READ_ONE) | (byte_in == OP_READ_TWO) | (byte_in == OP_READ_THREE);
   wire       in_data   = (phase_r == FLSRB_PH_DATA);

   always_comb begin
      phase_nxt  = phase_r;
      nbytes_nxt = nbytes_r;
      if (cs_b_s) begin
         phase_nxt  = FLSRB_PH_OPC;
         nbytes_nxt = 2'h0;
      end else if (byte_done) begin
         case (phase_r)
            FLSRB_PH_OPC: begin
               phase_nxt  = rd_in ? FLSRB_PH_READ : FLSRB_PH_DATA;
               nbytes_nxt = `FLSRB_NB_ONE;
            end
            FLSRB_PH_DATA: begin
               if (nbytes_r != `FLSRB_NB_MAX) begin
                  nbytes_nxt = 2'(nbytes_r + 2'h1);
               end
            end
            FLSRB_PH_READ: begin
               phase_nxt = FLSRB_PH_READ;
            end
            default: begin
               phase_nxt = FLSRB_PH_OPC;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase_r   <= FLSRB_PH_OPC;
         nbytes_r  <= 2'h0;
         bit_cnt_r <= 3'h0;
         shift_r   <= 8'h00;
      end else if (i_ce) begin
         phase_r   <= phase_nxt;
         nbytes_r  <= nbytes_nxt;
         bit_cnt_r <= cs_b_s ? 3'h0 : (sclk_rise ? 3'(bit_cnt_r + 3'h1) : bit_cnt_r);
         shift_r   <= sclk_rise ? byte_in : shift_r;
      end
   end

   // Captured bytes; reads reload from live state at every byte boundary
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         op_r    <= 8'h00;
         data1_r <= 8'h00;
         data2_r <= 8'h00;
         tx_r    <= 8'h00;
      end else if (i_ce) begin
         op_r    <= (byte_done && phase_r == FLSRB_PH_OPC) ? byte_in : op_r;
         data1_r <= (byte_done && in_data && nbytes_r == `FLSRB_NB_ONE) ? byte_in : data1_r;
         data2_r <= (byte_done && in_data && nbytes_r == `FLSRB_NB_TWO) ? byte_in : data2_r;
         if (sclk_fall && phase_r == FLSRB_PH_READ) begin
            tx_r <= (bit_cnt_r == 3'h0) ? rd_byte : {tx_r[6:0], 1'b0}; // R25
         end
      end
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic [7:0]   nv_one_r;
   logic [7:0]   nv_two_r;
   logic [7:0]   vol_one_r;
   logic [7:0]   vol_two_r;
   logic [7:0]   three_r;
   logic         wpl_r;
   logic         vol_en_r;
   logic         vol_done_r;
   logic         arm_r;
   logic         array_busy_r;
   logic         paused_r;
   logic         qpi_d_r;
   logic [3:0]   qpi_wait_r;
   logic [15:0]  srw_cnt_r;
   logic [15:0]  rst_cnt_r;

   wire busy    = array_busy_r | (srw_cnt_r != 16'h0000);                        // R01
   wire cmd_ok  = ~busy & (rst_cnt_r == 16'h0000);                               // R02
   wire run     = exec & cmd_ok & (bit_cnt_r == 3'h0);
   wire one_b   = (nbytes_r == `FLSRB_NB_ONE);
   wire has_d   = nbytes_r[1];
   wire c_wren  = run & one_b & (op_r == `FLSRB_OP_WREN);
   wire c_wrdi  = run & one_b & (op_r == OP_WRITE_DISABLE);
   wire c_vwen  = run & one_b & (op_r == `FLSRB_OP_VOL_WREN);
   wire c_arm   = run & one_b & (op_r == `FLSRB_OP_RST_ARM);
   wire c_reset = run & one_b & (op_r == `FLSRB_OP_RST_GO) & arm_r;
   wire w1      = run & has_d & (op_r == `FLSRB_OP_WR_ONE);
   wire w2      = run & has_d & (op_r == `FLSRB_OP_WR_TWO);
   wire w3      = run & has_d & (op_r == `FLSRB_OP_WR_THREE);
   wire srw     = w1 | w2 | w3;
   wire rst_evt = c_reset | i_hw_reset_req;

   // ----------------------------------------------------------------
   // Write permission
   // ----------------------------------------------------------------
   wire [1:0] guard    = {vol_two_r[`FLSRB_B2_GUARD_HI], vol_one_r[`FLSRB_B1_GUARD_LO]};
   wire       quad     = vol_two_r[`FLSRB_B2_QUAD];
   // Pin guard only counts while the pin is not a data line
   wire       guard_ok = (guard == `FLSRB_GUARD_SOFT) | ((guard == `FLSRB_GUARD_PIN) & (wp_hi_s | quad)); // R08 R15
   wire       nv_ok    = wpl_r & ~vol_en_r & ~vol_done_r & guard_ok;             // R16
   wire       vol_ok   = vol_en_r & guard_ok;
   wire       wr_one   = w1;
   wire       wr_two   = w2 | (w1 & (nbytes_r == `FLSRB_NB_MAX));
   wire [7:0] two_data = w2 ? data1_r : data2_r;
   wire       nv_wr    = (w1 | w2) & nv_ok;
   wire [7:0] one_mrg  = (vol_one_r & ~`FLSRB_M1_PROT) | (data1_r & `FLSRB_M1_PROT); // R06 R07 R09
   wire [7:0] two_mrg  = (vol_two_r & ~`FLSRB_M2_PROT) | (two_data & `FLSRB_M2_PROT); // R10 R14
   // Supply lock-down does not survive a reset
   wire       lockdown = nv_two_r[`FLSRB_B2_GUARD_HI] & ~nv_one_r[`FLSRB_B1_GUARD_LO];
   wire [7:0] two_load = lockdown ? (nv_two_r & ~`FLSRB_M2_GUARD_HI) : nv_two_r;
   wire       qpi_exit = qpi_d_r & ~i_qpi_mode;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   wire [7:0] nv_one_nxt = (wr_one & nv_ok) ? ((nv_one_r & ~`FLSRB_M1_PROT) | (data1_r & `FLSRB_M1_PROT)) : nv_one_r;
   // Lock bits only ever set, so a locked register never unlocks
   wire [7:0] nv_two_nxt = (wr_two & nv_ok) ?
                           ((nv_two_r & ~`FLSRB_M2_PROT) | (two_data & `FLSRB_M2_PROT) | (two_data & `FLSRB_M2_LOCK))
                           : nv_two_r;                                           // R12
   wire [7:0] vol_one_nxt = rst_evt ? nv_one_r : ((wr_one & (nv_ok | vol_ok)) ? one_mrg : vol_one_r); // R23
   wire [7:0] vol_two_nxt = rst_evt ? two_load : ((wr_two & (nv_ok | vol_ok)) ? two_mrg : vol_two_r); // R23
   wire [7:0] three_nxt = rst_evt ? `FLSRB_DEF_THREE :
                          (w3 & (vol_en_r | wpl_r)) ? data1_r :                  // R24
                          qpi_exit ? (three_r & ~`FLSRB_M3_WAIT) : three_r;      // R20
   wire       wpl_nxt   = c_wren | (wpl_r & ~(c_wrdi | srw | i_array_op_start | rst_evt)); // R04 R05
   wire       vol_en_nxt   = c_vwen | (vol_en_r & ~(srw | c_wren | rst_evt));
   wire       vol_done_nxt = ~rst_evt & (vol_done_r | ((w1 | w2) & vol_ok));    // R16
   wire       arm_nxt   = exec ? c_arm : arm_r;
   wire [15:0] srw_cnt_nxt = rst_evt ? 16'h0000 : nv_wr ? SRW_CYCLES :
                             (srw_cnt_r != 16'h0000) ? (srw_cnt_r - 16'h0001) : srw_cnt_r; // R01 R03
   wire [15:0] rst_cnt_nxt = rst_evt ? 16'(`FLSRB_RST_CYC) :
                             (rst_cnt_r != 16'h0000) ? (rst_cnt_r - 16'h0001) : rst_cnt_r;
   wire       array_busy_nxt = i_array_op_start | (array_busy_r & ~i_array_op_done & ~rst_evt); // R01 R03
   wire       paused_nxt = i_suspend_set | (paused_r & ~i_resume & ~rst_evt);    // R11
   wire [3:0] qpi_wait_nxt = rst_evt ? `FLSRB_DEF_WAIT : (i_qpi_wait_load ? i_qpi_wait_value : qpi_wait_r); // R21

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         nv_one_r  <= `FLSRB_DEF_ONE;
         nv_two_r  <= `FLSRB_DEF_TWO;
         vol_one_r <= `FLSRB_DEF_ONE;
         vol_two_r <= `FLSRB_DEF_TWO;
         three_r   <= `FLSRB_DEF_THREE;
      end else if (i_ce) begin
         nv_one_r  <= nv_one_nxt;
         nv_two_r  <= nv_two_nxt;
         vol_one_r <= vol_one_nxt;
         vol_two_r <= vol_two_nxt;
         three_r   <= three_nxt;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wpl_r        <= 1'b0;
         vol_en_r     <= 1'b0;
         vol_done_r   <= 1'b0;
         arm_r        <= 1'b0;
         array_busy_r <= 1'b0;
         paused_r     <= 1'b0;
         qpi_d_r      <= 1'b0;
         qpi_wait_r   <= `FLSRB_DEF_WAIT;
         srw_cnt_r    <= 16'h0000;
         rst_cnt_r    <= 16'h0000;
      end else if (i_ce) begin
         wpl_r        <= wpl_nxt;
         vol_en_r     <= vol_en_nxt;
         vol_done_r   <= vol_done_nxt;
         arm_r        <= arm_nxt;
         array_busy_r <= array_busy_nxt;
         paused_r     <= paused_nxt;
         qpi_d_r      <= i_qpi_mode;
         qpi_wait_r   <= qpi_wait_nxt;
         srw_cnt_r    <= srw_cnt_nxt;
         rst_cnt_r    <= rst_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Readback and outputs
   // ----------------------------------------------------------------
   wire [7:0] rd_one   = {vol_one_r[7:2], wpl_r, busy};                          // R25
   wire [7:0] rd_two   = {paused_r, vol_two_r[`FLSRB_B2_INVERT], nv_two_r[`FLSRB_B2_LOCK_HI:3], 1'b1,
                          vol_two_r[`FLSRB_B2_QUAD:`FLSRB_B2_GUARD_HI]};         // R13 R25
   assign rd_byte      = (op_r == OP_READ_ONE) ? rd_one : ((op_r == OP_READ_TWO) ? rd_two : three_r);

   assign o_so                  = tx_r[7];
   assign o_so_oe_b             = ~((phase_r == FLSRB_PH_READ) & ~cs_b_s);
   assign o_cmd_ready           = cmd_ok;
   assign o_busy                = busy;
   assign o_write_permit_latch  = wpl_r;
   assign o_paused_flag         = paused_r;
   assign o_status_byte_one     = rd_one;
   assign o_status_byte_two     = rd_two;
   assign o_status_byte_three   = three_r;
   assign o_protect_range       = vol_one_r[`FLSRB_B1_BP_HI:`FLSRB_B1_BP_LO];   // R06
   assign o_protect_from_bottom = vol_one_r[`FLSRB_B1_BOTTOM];                   // R07
   assign o_granule_size_select = vol_one_r[`FLSRB_B1_GRAN];                     // R09
   assign o_invert_protect_map  = vol_two_r[`FLSRB_B2_INVERT];                   // R10
   assign o_otp_lock            = {nv_two_r[`FLSRB_B2_LOCK_HI:3], 1'b1};         // R12 R13
   assign o_quad_io_enable      = quad;                                          // R14
   assign o_wp_pin_guard        = ~quad & (guard == `FLSRB_GUARD_PIN);           // R14 R15
   assign o_hold_enable         = ~quad & ~three_r[`FLSRB_B3_ROLE];              // R17
   assign o_reset_pin_enable    = ~quad & three_r[`FLSRB_B3_ROLE];               // R17
   assign o_pad_strength        = three_r[`FLSRB_B3_DRV_HI:`FLSRB_B3_DRV_LO];    // R22
   assign o_fast_quad_pump_on   = three_r[`FLSRB_B3_PUMP];                       // R18
   // Serial reads see the field; quad reads use the separately loaded value
   assign o_read_wait_cycles    = i_qpi_mode ? qpi_wait_r : three_r[`FLSRB_B3_WAIT_HI:`FLSRB_B3_WAIT_LO]; // R19 R20 R21

endmodule

// ### flsrb_status_bank_properties.sv
// Port checker for the flash status register bank.
// Assumes it is bound onto flsrb_status_bank.
module flsrb_props (
   input wire logic i_mclk, i_rst_b, i_ce, i_qpi_mode, i_array_op_start, i_array_op_done, i_suspend_set,
   input wire logic o_busy, o_write_permit_latch, o_paused_flag, o_cmd_ready, o_so_oe_b, o_quad_io_enable,
   input wire logic o_protect_from_bottom, o_granule_size_select, o_invert_protect_map, o_fast_quad_pump_on,
   input wire logic o_wp_pin_guard, o_hold_enable, o_reset_pin_enable,
   input wire logic [2:0] o_protect_range,
   input wire logic [3:0] o_otp_lock, o_read_wait_cycles,
   input wire logic [1:0] o_pad_strength,
   input flsrb_pkg::flsrb_byte_t o_status_byte_one, o_status_byte_two, o_status_byte_three
);
   import flsrb_pkg::*;
   // ----------------------------------------
   // Relations
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   property p_flags; o_busy == o_status_byte_one[0] && o_write_permit_latch == o_status_byte_one[1]
      && o_paused_flag == o_status_byte_two[7]; endproperty
   a_flags: assert property (p_flags) else $error("live flags differ from status bytes");
   property p_start; i_ce && i_array_op_start |-> ##[1:2] (o_busy && !o_write_permit_latch); endproperty
   a_start: assert property (p_start) else $error("start did not raise busy");
   property p_done; i_ce && i_array_op_done && !i_array_op_start |-> ##[1:2] !o_busy; endproperty
   a_done: assert property (p_done) else $error("done did not clear busy");
   property p_ignore; o_busy |-> !o_cmd_ready; endproperty
   a_ignore: assert property (p_ignore) else $error("ready while busy");
   property p_paused; i_ce && i_suspend_set |-> ##[1:2] o_paused_flag; endproperty
   a_paused: assert property (p_paused) else $error("suspend not flagged");
   property p_lock; o_otp_lock[0] && o_otp_lock == o_status_byte_two[5:2]; endproperty
   a_lock: assert property (p_lock) else $error("lock bits wrong");
   property p_prot; {o_granule_size_select, o_protect_from_bottom, o_protect_range} == o_status_byte_one[6:2]
      && o_invert_protect_map == o_status_byte_two[6]; endproperty
   a_prot: assert property (p_prot) else $error("protect fields differ");
   property p_quad; o_quad_io_enable |-> !(o_hold_enable || o_reset_pin_enable || o_wp_pin_guard); endproperty
   a_quad: assert property (p_quad) else $error("pin functions live under quad");
   property p_role; !o_quad_io_enable |-> o_reset_pin_enable == o_status_byte_three[7]
      && o_hold_enable != o_status_byte_three[7]; endproperty
   a_role: assert property (p_role) else $error("pin role wrong");
   property p_cfg; o_pad_strength == o_status_byte_three[6:5] && o_fast_quad_pump_on == o_status_byte_three[4];
   endproperty
   a_cfg: assert property (p_cfg) else $error("drive or pump bit wrong");
   property p_lat; !i_qpi_mode |-> o_read_wait_cycles == o_status_byte_three[3:0]; endproperty
   a_lat: assert property (p_lat) else $error("serial latency wrong");
   property p_lc_clr; i_ce && $fell(i_qpi_mode) |-> ##[1:3] o_status_byte_three[3:0] == 4'h0; endproperty
   a_lc_clr: assert property (p_lc_clr) else $error("latency kept after quad exit");
   c_busy: cover property ($rose(o_busy));
   c_read: cover property (!o_so_oe_b);
   c_quad: cover property (o_quad_io_enable);
endmodule
bind flsrb_status_bank flsrb_props u_props (.*);

// ### flsrb_host_model.sv
// Serial host model issuing status commands, mode 0.
// Assumes half clock periods of four core cycles.
module flsrb_host (
   input  wire logic i_mclk,
   input  wire logic i_so,
   output logic      o_sclk,
   output logic      o_cs_b,
   output logic      o_si
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sclk = 1'b0;
      o_cs_b = 1'b1;
      o_si = 1'b0;
   end
   // Clock stands low between frames; data flips after release
   task automatic frame(input logic [7:0] op, input logic [15:0] d, input int nb, output logic [7:0] rd);
      logic [23:0] sh;
      sh = {op, d};
      rd = 8'h00;
      @(posedge i_mclk) o_cs_b <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int i = 0; i < 8 * nb + 8; i++) begin
         o_si <= sh[23];
         sh = sh << 1;
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'b1;
         rd = {rd[6:0], i_so};
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_mclk);
      o_cs_b <= 1'b1;
      o_si <= ~o_si;
      repeat (8) @(posedge i_mclk);
   endtask
endmodule

// ### tb.sv
// Self-checking bench for the status register bank.
// Assumes the host model and the bound checker.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flsrb_pkg::*;
   logic i_mclk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_wp_b = 1'b1, i_qpi_mode = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [3:0] i_qpi_wait_value = 4'h0;
   wire i_sclk, i_cs_b, i_si, o_so, o_so_oe_b, o_cmd_ready, o_busy, o_write_permit_latch, o_paused_flag;
   wire [3:0] o_read_wait_cycles;
   flsrb_byte_t o_status_byte_one, o_status_byte_two, o_status_byte_three;
   int n_errors = 0, checked = 0, seed = 32'hb94d3ca1;
   flsrb_status_bank #(.SRW_CYCLES(16'h0180)) u_dut (.*, .i_array_op_start(ev[0]), .i_array_op_done(ev[1]),
      .i_suspend_set(ev[2]), .i_resume(ev[3]), .i_hw_reset_req(ev[4]), .i_qpi_wait_load(ev[5]),
      .o_protect_range(), .o_protect_from_bottom(), .o_granule_size_select(), .o_invert_protect_map(),
      .o_otp_lock(), .o_quad_io_enable(), .o_wp_pin_guard(), .o_hold_enable(), .o_reset_pin_enable(),
      .o_pad_strength(), .o_fast_quad_pump_on());
   flsrb_host u_host (.i_mclk, .i_so(o_so), .o_sclk(i_sclk), .o_cs_b(i_cs_b), .o_si(i_si));
   initial forever #20 i_mclk = ~i_mclk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] d = 16'h0000, input int nb = 0);
      logic [7:0] r;
      u_host.frame(op, d, nb, r);
   endtask
   task automatic rd(input logic [7:0] op, output logic [7:0] r);
      u_host.frame(op, 16'h0000, 1, r);
   endtask
   task automatic idle;
      int k;
      for (k = 0; k < 2000 && o_cmd_ready !== 1'b1; k++) @(negedge i_mclk);
      if (k == 2000) begin
         n_errors++;
         $display("ERROR cmd_ready expected 1 seen %b", o_cmd_ready);
      end
   endtask
   task automatic pulse(input int b);
      @(posedge i_mclk) ev[b] <= 1'b1;
      @(posedge i_mclk) ev[b] <= 1'b0;
      repeat (3) @(posedge i_mclk);
   endtask
   function automatic logic [7:0] e2(input logic [7:0] v, input logic [3:0] lk);
      return {1'b0, v[6], lk, v[1], 1'b0};
   endfunction
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      logic [7:0] r, a, b, c;
      logic [3:0] lk;
      lk = 4'h1;
      repeat (16) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rd(8'h05, r); chk("reset one", 8'h00, r);
      rd(8'h35, r); chk("reset two", 8'h04, r);
      rd(8'h15, r); chk("reset three", 8'h00, r);
      cmd(8'h06); rd(8'h05, r); chk("latch set", 8'h02, r);
      cmd(8'h04); chk("latch clear", 8'h00, o_status_byte_one);
      $display("test reset and latch done");
      for (int t = 0; t < 3; t++) begin
         a = $random(seed) & 8'h7c;
         b = $random(seed) & 8'h7e;
         lk = lk | b[5:2];
         cmd(8'h06); cmd(8'h01, {a, b}, 2);
         chk("busy after write", 8'h01, o_status_byte_one & 8'h03);
         cmd(8'h06); chk("enable ignored", 8'h01, o_status_byte_one & 8'h03);
         rd(8'h05, r); chk("read while busy", a | 8'h01, r);
         idle;
         chk("nv one", a, o_status_byte_one);
         chk("nv two", e2(b, lk), o_status_byte_two);
      end
      $display("test non-volatile writes done");
      c = $random(seed);
      cmd(8'h50); cmd(8'h11, {c, 8'h00}, 1); idle;
      chk("byte three", c, o_status_byte_three);
      cmd(8'h50); cmd(8'h01, 16'h1c00, 1); idle;
      chk("volatile one", 8'h1c, o_status_byte_one);
      cmd(8'h06); cmd(8'h01, 16'h0000, 1); idle;
      chk("nv after volatile", 8'h1c, o_status_byte_one);
      @(posedge i_mclk) i_qpi_wait_value <= 4'(~c[3:0]);
      i_qpi_mode <= 1'b1;
      pulse(5); chk("quad latency", {4'h0, ~c[3:0]}, {4'h0, o_read_wait_cycles});
      @(posedge i_mclk) i_qpi_mode <= 1'b0;
      repeat (4) @(posedge i_mclk);
      chk("latency cleared", c & 8'hf0, o_status_byte_three);
      $display("test volatile and latency done");
      cmd(8'h66); cmd(8'h99); idle;
      chk("reload one", a, o_status_byte_one);
      chk("reload three", 8'h00, o_status_byte_three);
      cmd(8'h06); cmd(8'h31, 16'h0000, 1); idle;
      chk("locks sticky", {2'h0, lk, 2'h0}, o_status_byte_two);
      pulse(4); idle;
      chk("hw reset two", {2'h0, lk, 2'h0}, o_status_byte_two);
      cmd(8'h06); pulse(0); chk("array start", 8'h01, o_status_byte_one & 8'h03);
      pulse(1); chk("array done", 8'h00, o_status_byte_one & 8'h03);
      pulse(2); chk("suspended", 8'h80, o_status_byte_two & 8'h80);
      pulse(3); chk("resumed", 8'h00, o_status_byte_two & 8'h80);
      $display("test reset and engine events done");
      complete_run;
   end
   initial begin
      repeat (60000) @(posedge i_mclk);
      n_errors++;
      $display("ERROR watchdog expected finish seen hang");
      complete_run;
   end
endmodule
